// ==== emb_top.sv ====
/*
   External memory bus interface: APB registers, pin muxing of the
   address/data and high address ports, internal RAM routing, stop.
   Assumes pins pass through a pad wrapper that resolves the enables.
*/
// Our own choices: the register addresses and the APB register port.
module emb_top (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire emb_pkg::emb_apb_req_type apb_req,
   output logic          [31:0] prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic      [7:0] ad_in,
   input  wire logic      [7:0] ah_in,
   input  wire logic            stop_n,
   input  wire logic            mode_pin_a,
   input  wire logic            mode_pin_b,
   output emb_pkg::emb_pins_type pins,
   output logic                 osc_run
);
   import emb_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]   mm;
      logic [7:0]   pfdir;
      logic [7:0]   pfout;
      logic         pddir;
      logic [7:0]   pdout;
      logic [15:0]  xaddr;
      logic [7:0]   xdata;
      logic         xwr;
      logic         go;
      logic         fault;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      emb_pins_type pins;
      logic         osc_run;
   } emb_top_st_type;

   emb_top_st_type s_ff;
   emb_top_st_type nxt_s;

   logic [7:0]  ram_mem [256];
   logic        ram_we;
   logic [18:0] sync_q;
   logic        stop_act;
   logic        mode_ok;
   logic        seq_ale;
   logic        seq_addr;
   logic        seq_rd;
   logic        seq_wr;
   logic        seq_busy;
   logic        seq_done;
   logic [7:0]  seq_rdata;
   logic [31:0] rv;
   logic        hit;
   logic        acc;
   logic        bus_on;
   logic [7:0]  amask;

   // ------------------------------------------------------------
   // Pin inputs and the cycle sequencer
   // ------------------------------------------------------------
   emb_sync3 #(.W(19)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({mode_pin_b, mode_pin_a, stop_n, ah_in, ad_in}),
      .q       (sync_q)
   );

   assign stop_act = ~sync_q[16];
   assign mode_ok  = ~sync_q[17] & sync_q[18];

   emb_xcyc u_xcyc (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (s_ff.go),
      .write   (s_ff.xwr),
      .abort   (stop_act),
      .rd_pin  (sync_q[7:0]),
      .ale_on  (seq_ale),
      .addr_on (seq_addr),
      .rd_on   (seq_rd),
      .wr_on   (seq_wr),
      .busy    (seq_busy),
      .done    (seq_done),
      .rdata   (seq_rdata)
   );

   // Only the enabling codes hand the ports to the bus
   assign bus_on = s_ff.mm[2];
   assign amask  = addr_mask(s_ff.mm[2:0]);
   assign acc    = apb_req.psel & apb_req.penable & s_ff.pready;

   // ------------------------------------------------------------
   // Register read decode
   // ------------------------------------------------------------
   always_comb begin
      rv = 32'h0000_0000;
      hit = 1'b1;
      case (apb_req.paddr)
         OFS_MEMMAP: rv[7:0] = s_ff.mm;
         OFS_PFDIR:  rv[7:0] = s_ff.pfdir;
         OFS_PFOUT:  rv[7:0] = s_ff.pfout;
         OFS_PDDIR:  rv[0] = s_ff.pddir;
         OFS_PDOUT:  rv[7:0] = s_ff.pdout;
         OFS_XADDR:  rv[15:0] = s_ff.xaddr;
         OFS_XDATA:  rv[7:0] = s_ff.xdata;
         OFS_XCTRL:  rv[1:0] = {s_ff.xwr, s_ff.go | seq_busy};
         OFS_STAT:   rv = {8'h00, sync_q[15:8], sync_q[7:0], 4'h0,
                           s_ff.fault, mode_ok, stop_act,
                           s_ff.go | seq_busy};
         default:    hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      ram_we = 1'b0;
      nxt_s.go = 1'b0;
      // One wait state: answer is registered with its data
      nxt_s.pready = apb_req.psel & apb_req.penable & ~s_ff.pready;
      nxt_s.prdata = rv;
      nxt_s.pslverr = nxt_s.pready & ~hit;
      if (acc && apb_req.pwrite && hit) begin
         case (apb_req.paddr)
            OFS_MEMMAP: nxt_s.mm = apb_req.pwdata[7:0];
            OFS_PFDIR:  nxt_s.pfdir = apb_req.pwdata[7:0];
            OFS_PFOUT:  nxt_s.pfout = apb_req.pwdata[7:0];
            OFS_PDDIR:  nxt_s.pddir = apb_req.pwdata[0];
            OFS_PDOUT:  nxt_s.pdout = apb_req.pwdata[7:0];
            OFS_XADDR:  if (!seq_busy) begin
               nxt_s.xaddr = apb_req.pwdata[15:0];
            end
            OFS_XDATA:  if (!seq_busy) begin
               nxt_s.xdata = apb_req.pwdata[7:0];
            end
            OFS_XCTRL:  if (!seq_busy && apb_req.pwdata[XC_GO_BIT]) begin
               nxt_s.xwr = apb_req.pwdata[XC_WR_BIT];
               nxt_s.fault = 1'b0;
               // RAM window goes inside only while enabled
               if (s_ff.xaddr >= RAM_BASE && s_ff.mm[MM_RAE_BIT]) begin
                  ram_we = apb_req.pwdata[XC_WR_BIT];
                  if (!apb_req.pwdata[XC_WR_BIT]) begin
                     nxt_s.xdata = ram_mem[s_ff.xaddr[7:0]];
                  end
               // Vectors and calls sit below every limit
               end else if (s_ff.xaddr < FIXED_END ||
                            s_ff.xaddr < rom_limit(s_ff.mm[7:5]) ||
                            !bus_on) begin
                  nxt_s.fault = 1'b1;
               end else begin
                  nxt_s.go = 1'b1;
               end
            end
            default: nxt_s.mm = s_ff.mm;
         endcase
      end
      if (seq_done && !s_ff.xwr) begin
         nxt_s.xdata = seq_rdata;
      end

      // Low port: address, then write data; otherwise released in bus mode, driven per pddir in port mode
      if (seq_addr) begin
         nxt_s.pins.ad_out = s_ff.xaddr[7:0];
         nxt_s.pins.ad_oe = 1'b1;
      end else if (seq_wr) begin
         nxt_s.pins.ad_out = s_ff.xdata;
         nxt_s.pins.ad_oe = 1'b1;
      end else if (bus_on) begin
         nxt_s.pins.ad_out = s_ff.pdout;
         nxt_s.pins.ad_oe = 1'b0;
      end else begin
         nxt_s.pins.ad_out = s_ff.pdout;
         nxt_s.pins.ad_oe = s_ff.pddir;
      end
      // High port: claimed bits carry address, rest stay ports
      nxt_s.pins.ah_oe = amask | (~amask & s_ff.pfdir);
      nxt_s.pins.ah_out = (amask & s_ff.xaddr[15:8]) |
                          (~amask & s_ff.pfout);
      nxt_s.pins.ale = seq_ale;
      nxt_s.pins.rd_n = ~seq_rd;
      nxt_s.pins.wr_n = ~seq_wr;
      nxt_s.pins.strobe_oe = ~stop_act;
      nxt_s.osc_run = ~stop_act;

      // Stop drops configuration and map, keeps RAM enable
      if (stop_act) begin
         nxt_s.mm[2:0] = CFG_PORT;
         nxt_s.mm[7:5] = 3'h0;
         nxt_s.go = 1'b0;
      end
   end

   // Reset is asynchronous and active low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{MM_RST, 8'h00, 8'h00, 1'b0, 8'h00, 16'h0000, 8'h00,
                   1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0000,
                   PINS_RST, 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // RAM has no reset so contents ride through stop
   always_ff @(posedge pclk) begin
      if (ram_we) begin
         ram_mem[s_ff.xaddr[7:0]] <= s_ff.xdata;
      end
   end

   assign prdata  = s_ff.prdata;
   assign pready  = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign pins    = s_ff.pins;
   assign osc_run = s_ff.osc_run;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Cycle walk: latch pulse, one hold cycle, then a strobe
   sequence latch_end_s;
      pins.ale ##1 !pins.ale;
   endsequence

   sequence latch_pulse_s;
      pins.ale[*2] ##1 !pins.ale;
   endsequence

   sequence strobe_low_s;
      !pins.rd_n || !pins.wr_n;
   endsequence

   strobe_float_a: assert property (stop_act |=>
      !pins.strobe_oe) else $error("strobes not floated in stop");
   osc_halt_a: assert property (stop_act |=> !osc_run)
      else $error("oscillator runs in stop");
   cfg_clear_a: assert property (stop_act |=>
      s_ff.mm[2:0] == CFG_PORT && s_ff.mm[7:5] == 3'h0)
      else $error("configuration kept in stop");
   wr_strobe_a: assert property (pins.wr_n == !$past(seq_wr))
      else $error("write strobe wrong");
   rd_strobe_a: assert property (!pins.rd_n |->
      pins.wr_n && !pins.ad_oe && $past(bus_on))
      else $error("read strobe outside read");
   addr_latch_a: assert property (pins.ale |->
      pins.ad_oe && pins.ad_out == s_ff.xaddr[7:0] && pins.rd_n)
      else $error("latch strobe without address");
   addr_hold_a: assert property (latch_end_s |->
      pins.ad_oe && pins.ad_out == s_ff.xaddr[7:0] && pins.rd_n
      && pins.wr_n) else $error("address dropped at latch end");
   upper_addr_a: assert property ($past(bus_on) && bus_on
      && $stable(s_ff.mm) |-> pins.ah_oe == (amask | (~amask &
      $past(s_ff.pfdir)))) else $error("high port enables wrong");
   ram_route_a: assert property (ram_we |->
      s_ff.mm[MM_RAE_BIT] && s_ff.xaddr >= RAM_BASE)
      else $error("RAM written while disabled");
   high_addr_a: assert property (pins.ale |->
      (pins.ah_out & amask) == (s_ff.xaddr[15:8] & amask))
      else $error("upper address missing at latch");
   // A stop cuts the walk short, so these stand aside then
   ale_width_a: assert property (
      disable iff (!presetn || stop_act)
      $rose(pins.ale) |-> latch_pulse_s)
      else $error("latch strobe width wrong");
   data_phase_a: assert property (
      disable iff (!presetn || stop_act)
      latch_end_s |=> strobe_low_s)
      else $error("no strobe after address hold");
   wr_data_a: assert property (!pins.wr_n && pins.strobe_oe |->
      pins.ad_oe && pins.ad_out == s_ff.xdata)
      else $error("write data not on port");
endmodule

// ==== emb_pkg.sv ====
/*
   Shared constants, types and helpers of the external memory bus block.
   Assumes a single 20 MHz clock and a 32-bit APB register bus.
*/
package emb_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_MEMMAP = 12'h000;
   localparam logic [11:0] OFS_PFDIR  = 12'h004;
   localparam logic [11:0] OFS_PFOUT  = 12'h008;
   localparam logic [11:0] OFS_PDDIR  = 12'h00c;
   localparam logic [11:0] OFS_PDOUT  = 12'h010;
   localparam logic [11:0] OFS_XADDR  = 12'h014;
   localparam logic [11:0] OFS_XDATA  = 12'h018;
   localparam logic [11:0] OFS_XCTRL  = 12'h01c;
   localparam logic [11:0] OFS_STAT   = 12'h020;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam int MM_RAE_BIT = 3;
   localparam int MM_ROM_LSB = 5;
   localparam int XC_GO_BIT  = 0;
   localparam int XC_WR_BIT  = 1;
   localparam logic [7:0] MM_RST = 8'h00;
   localparam logic [2:0] CFG_PORT = 3'h0;
   localparam logic [2:0] CFG_256  = 3'h4;
   localparam logic [2:0] CFG_4K   = 3'h5;
   localparam logic [2:0] CFG_16K  = 3'h6;
   localparam logic [2:0] CFG_FULL = 3'h7;
   localparam logic [2:0] ROM_4K   = 3'h4;
   localparam logic [2:0] ROM_8K   = 3'h5;
   localparam logic [2:0] ROM_16K  = 3'h6;
   localparam logic [15:0] LIM_4K  = 16'h1000;
   localparam logic [15:0] LIM_8K  = 16'h2000;
   localparam logic [15:0] LIM_16K = 16'h4000;
   localparam logic [15:0] LIM_32K = 16'h8000;
   localparam logic [15:0] FIXED_END = 16'h00c0;
   localparam logic [15:0] RAM_BASE  = 16'hff00;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int ALE_NS  = 100;
   localparam int HOLD_NS = 50;
   localparam int STB_NS  = 150;

   // Least time rounded up to whole cycles, never below one
   function automatic logic [3:0] ns_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      if (c < 1) begin
         c = 1;
      end
      return c[3:0];
   endfunction

   localparam logic [3:0] ALE_CYC  = ns_cyc(ALE_NS);
   localparam logic [3:0] HOLD_CYC = ns_cyc(HOLD_NS);
   localparam logic [3:0] STB_CYC  = ns_cyc(STB_NS);
   // Read capture waits for the pin flops to agree on the data
   localparam logic [3:0] SYNC_CYC = 4'h4;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {XS_IDLE, XS_ADDR, XS_HOLD, XS_DATA,
                             XS_DONE} emb_xst_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } emb_apb_req_type;

   typedef struct packed {
      logic [7:0] ad_out;
      logic       ad_oe;
      logic [7:0] ah_out;
      logic [7:0] ah_oe;
      logic       ale;
      logic       rd_n;
      logic       wr_n;
      logic       strobe_oe;
   } emb_pins_type;

   localparam emb_pins_type PINS_RST = '{8'h00, 1'b0, 8'h00, 8'h00,
                                         1'b0, 1'b1, 1'b1, 1'b0};

   // Upper address bits claimed by the bus for each size
   function automatic logic [7:0] addr_mask(input logic [2:0] cfg);
      case (cfg)
         CFG_256:  return 8'h00;
         CFG_4K:   return 8'h0f;
         CFG_16K:  return 8'h3f;
         CFG_FULL: return 8'hff;
         default:  return 8'h00;
      endcase
   endfunction

   // First address above internal program memory per map mode
   function automatic logic [15:0] rom_limit(input logic [2:0] rom);
      case (rom)
         ROM_4K:  return LIM_4K;
         ROM_8K:  return LIM_8K;
         ROM_16K: return LIM_16K;
         default: return LIM_32K;
      endcase
   endfunction
endpackage

// ==== emb_sync3.sv ====
/*
   Three-stage input synchroniser with agreement filter.
   Assumes inputs asynchronous to pclk; output resets to all ones.
*/
module emb_sync3 #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import emb_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } emb_sync_st_type;

   emb_sync_st_type s_ff;
   emb_sync_st_type nxt_s;

   // A bit is taken only once stages two and three agree
   always_comb begin
      nxt_s = s_ff;
      nxt_s.s1 = d;
      nxt_s.s2 = s_ff.s1;
      nxt_s.s3 = s_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (s_ff.s2[i] == s_ff.s3[i]) begin
            nxt_s.q[i] = s_ff.s3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign q = s_ff.q;
endmodule

// ==== emb_xcyc.sv ====
/*
   External bus cycle sequencer: address, hold, strobe, done phases.
   Assumes the top registers the phase flags onto the pins.
*/
module emb_xcyc (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic       write,
   input  wire logic       abort,
   input  wire logic [7:0] rd_pin,
   output logic            ale_on,
   output logic            addr_on,
   output logic            rd_on,
   output logic            wr_on,
   output logic            busy,
   output logic            done,
   output logic      [7:0] rdata
);
   import emb_pkg::*;

   typedef struct packed {
      emb_xst_type st;
      logic [3:0]  cnt;
      logic        wr;
      logic [7:0]  rdata;
   } emb_xcyc_st_type;

   emb_xcyc_st_type s_ff;
   emb_xcyc_st_type nxt_s;

   // Phase walk; address stays out through the hold phase
   always_comb begin
      nxt_s = s_ff;
      case (s_ff.st)
         XS_IDLE: if (start) begin
            nxt_s.st = XS_ADDR;
            nxt_s.cnt = ALE_CYC;
            nxt_s.wr = write;
         end
         XS_ADDR: if (s_ff.cnt == 4'h1) begin
            nxt_s.st = XS_HOLD;
            nxt_s.cnt = HOLD_CYC;
         end else begin
            nxt_s.cnt = s_ff.cnt - 4'h1;
         end
         XS_HOLD: if (s_ff.cnt == 4'h1) begin
            nxt_s.st = XS_DATA;
            nxt_s.cnt = STB_CYC;
         end else begin
            nxt_s.cnt = s_ff.cnt - 4'h1;
         end
         XS_DATA: if (s_ff.cnt == 4'h1) begin
            nxt_s.st = XS_DONE;
            nxt_s.cnt = SYNC_CYC;
         end else begin
            nxt_s.cnt = s_ff.cnt - 4'h1;
         end
         // Pin data lags four flops, so it is taken late in done
         XS_DONE: if (s_ff.cnt == 4'h1) begin
            nxt_s.st = XS_IDLE;
         end else begin
            nxt_s.cnt = s_ff.cnt - 4'h1;
            if (s_ff.cnt == 4'h2 && !s_ff.wr) begin
               nxt_s.rdata = rd_pin;
            end
         end
         default: nxt_s.st = XS_IDLE;
      endcase
      // Stop kills a cycle in flight; memory sees strobes float
      if (abort) begin
         nxt_s.st = XS_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{XS_IDLE, 4'h0, 1'b0, 8'h00};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ale_on  = (s_ff.st == XS_ADDR);
   assign addr_on = (s_ff.st == XS_ADDR) || (s_ff.st == XS_HOLD);
   assign rd_on   = (s_ff.st == XS_DATA) && !s_ff.wr;
   assign wr_on   = (s_ff.st == XS_DATA) && s_ff.wr;
   assign busy    = (s_ff.st != XS_IDLE);
   assign done    = (s_ff.st == XS_DONE) && (s_ff.cnt == 4'h1);
   assign rdata   = s_ff.rdata;

   // Strobe width is exactly the strobe count
   strobe_width_a: assert property (@(posedge pclk)
      disable iff (!presetn || abort)
      $rose(rd_on || wr_on) && !abort |->
      (rd_on || wr_on)[*3] ##1 !(rd_on || wr_on))
      else $error("strobe width wrong");
endmodule

// ==== emb_xmem.sv ====
/*
   Far side model: byte memory behind a low address latch.
   Assumes the bench resolves the shared low port into ad_bus.
*/
module emb_xmem #(
   parameter int DLY = 0
) (
   input  wire logic                  pclk,
   input  wire emb_pkg::emb_pins_type pins,
   input  wire logic            [7:0] ad_bus,
   output logic                       mem_oe,
   output logic                 [7:0] mem_q
);
   import emb_pkg::*;
   // ------------------------------
   // Latch and array
   // ------------------------------
   logic [7:0] lat_lo;
   logic [7:0] mem [0:65535];
   int         waited = 0;

   // Transparent while ale is high, shut on its fall
   always @(pins.ale or ad_bus) begin
      if (pins.ale)
         lat_lo = ad_bus;
   end

   // Byte taken at every edge of a low write strobe, last one wins
   always @(posedge pclk) begin
      if (pins.strobe_oe && !pins.wr_n)
         mem[{pins.ah_out, lat_lo}] <= ad_bus;
      waited <= (pins.strobe_oe && !pins.rd_n) ? waited + 1 : 0;
   end

   // DLY above zero models a slow part
   assign mem_oe = pins.strobe_oe && !pins.rd_n && waited >= DLY;
   assign mem_q  = mem[{pins.ah_out, lat_lo}];
endmodule

// ==== tb_top.sv ====
/*
   Self-checking bench of the external memory bus block.
   Assumes emb_xmem as far side; the APB master lives here.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import emb_pkg::*;
   // ------------------------------
   // Signals
   // ------------------------------
   logic            pclk;
   logic            presetn;
   emb_apb_req_type apb_req;
   logic     [31:0] prdata;
   logic            pready;
   logic            pslverr;
   logic      [7:0] ad_in;
   logic      [7:0] ah_in;
   logic      [7:0] ah_ext;
   logic      [7:0] ad_last = 8'h00;
   logic            stop_n;
   logic            mode_pin_a;
   logic            mode_pin_b;
   emb_pins_type    pins;
   logic            osc_run;
   logic            mem_oe;
   logic      [7:0] mem_q;
   logic     [31:0] rd;
   logic            err;
   logic            ale_q = 1'b0;
   logic      [7:0] lo_a;
   logic      [7:0] hi_a;
   int              fail_count = 0;
   int              tests_run = 0;
   int              n_ale = 0;
   int              n_rd = 0;
   int              n_wr = 0;
   int              n_bad = 0;
   int              a0;
   int              r0;
   int              w0;

   emb_top emb_top_i (
      .pclk       (pclk),
      .presetn    (presetn),
      .apb_req    (apb_req),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .ad_in      (ad_in),
      .ah_in      (ah_in),
      .stop_n     (stop_n),
      .mode_pin_a (mode_pin_a),
      .mode_pin_b (mode_pin_b),
      .pins       (pins),
      .osc_run    (osc_run)
   );

   emb_xmem emb_xmem_i (
      .pclk   (pclk),
      .pins   (pins),
      .ad_bus (ad_in),
      .mem_oe (mem_oe),
      .mem_q  (mem_q)
   );

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Released low port shows the inverse of its last level
   always @(posedge pclk) ad_last <= ad_in;
   assign ad_in = pins.ad_oe ? pins.ad_out : mem_oe ? mem_q : ~ad_last;
   assign ah_in = (pins.ah_out & pins.ah_oe) | (ah_ext & ~pins.ah_oe);

   // Strobe widths; low address must outlive ale by the hold cycle
   always @(posedge pclk) begin
      ale_q <= pins.ale;
      if (pins.ale) begin
         n_ale <= n_ale + 1;
         lo_a <= pins.ad_out;
         hi_a <= pins.ah_out & pins.ah_oe;
      end
      if (!pins.rd_n) n_rd <= n_rd + 1;
      if (!pins.wr_n) n_wr <= n_wr + 1;
      if (pins.strobe_oe && ((pins.ale && !pins.ad_oe) || (ale_q &&
          !pins.ale && (!pins.ad_oe || pins.ad_out !== lo_a))))
         n_bad <= n_bad + 1;
   end

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic results;
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One access; an idle edge after it keeps drives one per step
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int t;
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1);
      chk("pready_wait", 2, t);
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
      @(posedge pclk);
   endtask

   task automatic snap;
      a0 = n_ale;
      r0 = n_rd;
      w0 = n_wr;
   endtask

   // Start a cycle and poll status until busy clears
   task automatic xgo(input logic [15:0] a, input logic [7:0] d,
                      input logic w);
      int t;
      apb(1, OFS_XADDR, {16'h0, a});
      apb(1, OFS_XDATA, {24'h0, d});
      apb(1, OFS_XCTRL, {30'h0, w, 1'b1});
      t = 0;
      do begin
         apb(0, OFS_STAT, 0);
         t++;
      end while (rd[0] !== 1'b0 && t < 30);
      chk("busy", 0, rd[0]);
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic s_reset;
      chk("strobe_oe", 0, pins.strobe_oe);
      chk("osc_run", 0, osc_run);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("run", 3, {pins.strobe_oe, osc_run});
      apb(0, OFS_MEMMAP, 0);
      chk("memmap", 0, rd);
      apb(0, 12'h024, 0);
      chk("slverr", 1, err);
      chk("unmapped", 0, rd);
   endtask

   task automatic s_port;
      logic [7:0] mk [4] = '{8'h00, 8'h0f, 8'h3f, 8'hff};
      apb(1, OFS_PFDIR, 32'ha0);
      apb(1, OFS_PFOUT, 32'hf5);
      for (int i = 0; i < 4; i++) begin
         apb(1, OFS_MEMMAP, {29'h0, CFG_256 + 3'(i)});
         @(posedge pclk);
         chk("ah_oe", mk[i] | 8'ha0, pins.ah_oe);
         chk("ah_gp", 8'ha0 & ~mk[i], pins.ah_out & 8'ha0 & ~mk[i]);
      end
      apb(1, OFS_MEMMAP, 0);
      apb(1, OFS_PDOUT, 32'h96);
      apb(1, OFS_PDDIR, 32'h1);
      @(posedge pclk);
      chk("pd_out", 9'h196, {pins.ad_oe, pins.ad_out});
      chk("pf_dir", 8'ha0, pins.ah_oe);
      apb(1, OFS_PDDIR, 0);
      repeat (5) @(posedge pclk);
      chk("pd_in", 0, pins.ad_oe);
      apb(0, OFS_STAT, 0);
      chk("pf_pins", 8'hbc, rd[23:16]);
   endtask

   task automatic s_ext;
      apb(1, OFS_MEMMAP, {29'h0, CFG_FULL});
      snap();
      xgo(16'h9a5c, 8'hc3, 1'b1);
      chk("ale_len", ALE_CYC, n_ale - a0);
      chk("wr_len", STB_CYC, n_wr - w0);
      chk("rd_idle", 0, n_rd - r0);
      chk("lo_addr", 8'h5c, lo_a);
      chk("hi_addr", 8'h9a, hi_a);
      chk("mem", 8'hc3, emb_xmem_i.mem[16'h9a5c]);
      xgo(16'h9a5c, 8'h00, 1'b0);
      chk("rd_len", STB_CYC, n_rd - r0);
      chk("wr_idle", STB_CYC, n_wr - w0);
      apb(0, OFS_XDATA, 0);
      chk("rdata", 8'hc3, rd);
   endtask

   task automatic s_map;
      logic [15:0] lim [4] = '{LIM_4K, LIM_8K, LIM_16K, LIM_32K};
      for (int i = 0; i < 4; i++) begin
         apb(1, OFS_MEMMAP, {24'h0, 3'(i + 4), 5'h07});
         snap();
         xgo(lim[i] - 16'h1, 8'h00, 1'b1);
         chk("below_rom", 1, rd[3]);
         xgo(16'h0040, 8'h00, 1'b1);
         chk("vector", 1, rd[3]);
         xgo(lim[i], 8'h00, 1'b1);
         chk("above_rom", 0, rd[3]);
         chk("ext_cnt", ALE_CYC, n_ale - a0);
      end
   endtask

   task automatic s_stop;
      apb(1, OFS_MEMMAP, 32'h0f);
      snap();
      xgo(16'hff10, 8'h5a, 1'b1);
      chk("ram_int", 0, n_ale - a0);
      apb(1, OFS_XADDR, 32'h9a5c);
      apb(1, OFS_XCTRL, 32'h1);
      // Stop lands inside the read strobe
      repeat (1) @(posedge pclk);
      stop_n <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("stop", 0, {pins.strobe_oe, pins.ad_oe});
      chk("osc", 0, osc_run);
      stop_n <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(0, OFS_MEMMAP, 0);
      chk("mm_stop", 0, rd & 32'he7);
      apb(1, OFS_MEMMAP, 32'h0f);
      xgo(16'hff10, 8'h00, 1'b0);
      apb(0, OFS_XDATA, 0);
      chk("ram_keep", 8'h5a, rd);
      apb(1, OFS_MEMMAP, 32'h07);
      xgo(16'hff10, 8'h11, 1'b1);
      chk("ram_ext", 8'h11, emb_xmem_i.mem[16'hff10]);
   endtask

   task automatic s_mode;
      for (int i = 0; i < 4; i++) begin
         mode_pin_a <= i[0];
         mode_pin_b <= i[1];
         repeat (6) @(posedge pclk);
         apb(0, OFS_STAT, 0);
         chk("mode_ok", i == 2, rd[2]);
      end
   endtask

   // ------------------------------
   // Main sequence and watchdog
   // ------------------------------
   initial begin
      presetn = 1'b0;
      stop_n = 1'b1;
      mode_pin_a = 1'b0;
      mode_pin_b = 1'b1; // Normal operating mode
      ah_ext = 8'h3c;
      apb_req = '0;
      repeat (3) @(posedge pclk);
      s_reset();
      s_port();
      s_ext();
      s_map();
      s_stop();
      s_mode();
      chk("addr_hold", 0, n_bad);
      results();
   end

   // Run needs a few hundred cycles; 20000 means a hang
   initial begin
      #1ms;
      fail_count++;
      results();
   end
endmodule
